// ---- hw/mics_sequencer.sv ----
// Memory init command sequencer: command/data registers and opcode dispatch
`timescale 1ns/100ps
`default_nettype none
module mics_sequencer (
   // Clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       rst,
   // Configuration register port
   input  wire mics_pkg::mics_cfg_req_type cfg_req,
   output logic [31:0]                     cfg_rdata,
   // Serial control chain
   output logic                            ser_clk,
   output logic                            ser_cmd,
   output logic [1:0]                      ser_chan,
   input  wire logic                       ser_din,
   // Channel interface expansion configuration
   output logic [31:0]                     exp_cfg_a,
   output logic [31:0]                     exp_cfg_b,
   output logic                            clamp_en_a,
   output logic                            clamp_en_b
);
   typedef enum logic [1:0] {SQ_IDLE, SQ_SERIAL, SQ_FINISH} mics_sq_state_type;
   typedef struct packed {
      mics_sq_state_type st;
      logic [31:0] data;
      logic [31:0] cmd;
      logic [31:0] exp_a;
      logic [31:0] exp_b;
      logic        go;
   } mics_sq_type;
   mics_sq_type q, d;
   mics_pkg::mics_op_type op;
   logic        ss_done;
   logic [31:0] ss_rdata;
   logic        is_read;

   // One driver for the whole operation word
   assign op = '{bcast:    q.cmd[mics_pkg::BCAST_BIT],
                 reg_addr: q.cmd[mics_pkg::DRA_HI:mics_pkg::DRA_LO],
                 dev_id:   q.cmd[mics_pkg::SID_HI:mics_pkg::SID_LO],
                 opcode:   q.cmd[mics_pkg::OP_HI:mics_pkg::OP_LO],
                 channel:  q.cmd[mics_pkg::CHAN_HI:mics_pkg::CHAN_LO]};
   assign is_read     = (op.opcode == mics_pkg::OP_REG_READ);

   assign exp_cfg_a  = q.exp_a;
   assign exp_cfg_b  = q.exp_b;
   assign clamp_en_a = (q.exp_a[mics_pkg::CLAMP_HI:mics_pkg::CLAMP_LO] == mics_pkg::CLAMP_ON);
   assign clamp_en_b = (q.exp_b[mics_pkg::CLAMP_HI:mics_pkg::CLAMP_LO] == mics_pkg::CLAMP_ON);

   // Only data and command words are decoded; expansion words have no address
   always_comb begin
      unique case (cfg_req.addr)
         mics_pkg::OFS_DATA: cfg_rdata = q.data;
         mics_pkg::OFS_CMD:  cfg_rdata = q.cmd;
         default:            cfg_rdata = 32'h0000_0000;
      endcase
   end

   always_comb begin
      d = q;
      d.go = 1'b0;
      if (cfg_req.wr && cfg_req.addr == mics_pkg::OFS_DATA && q.st == SQ_IDLE) begin
         d.data = cfg_req.wdata;
      end
      // Writes are held off while busy so the operation's fields stay stable
      if (cfg_req.wr && cfg_req.addr == mics_pkg::OFS_CMD && q.st == SQ_IDLE) begin
         d.cmd = cfg_req.wdata & mics_pkg::CMD_WMASK;
         d.go = cfg_req.wdata[mics_pkg::INIT_BIT];
      end
      unique case (q.st)
         SQ_IDLE: begin
            if (q.go) begin
               unique case (op.opcode)
                  mics_pkg::OP_LOAD_A: begin
                     d.exp_a = q.data & mics_pkg::EXP_CFG_WMASK;
                     d.st = SQ_FINISH;
                  end
                  mics_pkg::OP_LOAD_B: begin
                     d.exp_b = q.data & mics_pkg::EXP_CFG_WMASK;
                     d.st = SQ_FINISH;
                  end
                  5'h03, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0c, 5'h0e, 5'h0f, 5'h1e, 5'h1f:
                     d.st = SQ_FINISH;
                  default: d.st = SQ_SERIAL;
               endcase
            end
         end
         SQ_SERIAL: begin
            if (ss_done) begin
               if (is_read) begin
                  d.data = ss_rdata;
               end
               d.st = SQ_FINISH;
            end
         end
         SQ_FINISH: begin
            d.cmd[mics_pkg::INIT_BIT] = 1'b0;
            d.st = SQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q.st    <= SQ_IDLE;
         q.data  <= mics_pkg::DATA_RESET;
         q.cmd   <= mics_pkg::CMD_RESET;
         q.exp_a <= mics_pkg::EXP_CFG_RESET;
         q.exp_b <= mics_pkg::EXP_CFG_RESET;
         q.go    <= 1'b0;
      end else begin
         q <= d;
      end
   end

   mics_serial_shift u_shift (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .start    (q.st == SQ_IDLE && d.st == SQ_SERIAL),
      .op       (op),
      .wdata    (q.data),
      .is_read  (is_read),
      .done     (ss_done),
      .rdata    (ss_rdata),
      .ser_clk  (ser_clk),
      .ser_cmd  (ser_cmd),
      .ser_chan (ser_chan),
      .ser_din  (ser_din)
   );
endmodule // mics_sequencer
`default_nettype wire

// ---- include/mics_pkg.sv ----
// Package of constants and types for the memory init command sequencer
// Functional notes
// - Broadcast bit sends operation to all devices
// - Register address from command bits 18:10
// - Target serial ID from command bits 9:5
// - Opcode in bits 4:0 selects operation
// - Opcode zero reads a device register
// - Opcode 11001b loads data into interface A
// - Opcode 11010b loads data into interface B
// - Both expansion configurations reset to zero
// - Bits 25:24 enable clamp, rest reserved
// - Expansion configurations have no own address
// - Initiate bit starts operation, cleared when done
// - Read data valid when initiate clears
// - Channel field bits 21:20 selects channel
package mics_pkg;
   localparam logic [7:0]  OFS_DATA      = 8'h90;
   localparam logic [7:0]  OFS_CMD       = 8'h94;
   localparam logic [31:0] EXP_CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] CMD_RESET     = 32'h0000_0000;
   localparam logic [31:0] DATA_RESET    = 32'h0000_0000;
   localparam int INIT_BIT   = 23;
   localparam int CHAN_HI    = 21;
   localparam int CHAN_LO    = 20;
   localparam int BCAST_BIT  = 19;
   localparam int DRA_HI     = 18;
   localparam int DRA_LO     = 10;
   localparam int SID_HI     = 9;
   localparam int SID_LO     = 5;
   localparam int OP_HI      = 4;
   localparam int OP_LO      = 0;
   localparam int CLAMP_HI   = 25;
   localparam int CLAMP_LO   = 24;
   // Writable command bits: 23 and 21:0
   localparam logic [31:0] CMD_WMASK     = 32'h00bf_ffff;
   localparam logic [31:0] EXP_CFG_WMASK = 32'h0300_0000;
   localparam logic [1:0]  CLAMP_ON      = 2'h3;
   localparam logic [4:0]  OP_REG_READ   = 5'h00;
   localparam logic [4:0]  OP_LOAD_A     = 5'h19;
   localparam logic [4:0]  OP_LOAD_B     = 5'h1a;
   localparam int SER_BITS   = 32;
   localparam int FRAME_BITS = 24;
   // Serial clock half-period 100 ns at 100 MHz
   localparam int SER_PERIOD_NS = 100;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SER_DIV = SER_PERIOD_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic       bcast;
      logic [8:0] reg_addr;
      logic [4:0] dev_id;
      logic [4:0] opcode;
      logic [1:0] channel;
   } mics_op_type;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } mics_cfg_req_type;
endpackage

// ---- hw/mics_serial_shift.sv ----
// Serial shifter for one control-chain operation
`timescale 1ns/100ps
`default_nettype none
module mics_serial_shift (
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   // Operation request
   input  wire logic                  start,
   input  wire mics_pkg::mics_op_type op,
   input  wire logic [31:0]           wdata,
   input  wire logic                  is_read,
   output logic                       done,
   output logic [31:0]                rdata,
   // Serial chain pins
   output logic                       ser_clk,
   output logic                       ser_cmd,
   output logic [1:0]                 ser_chan,
   input  wire logic                  ser_din
);
   typedef enum logic [1:0] {SS_IDLE, SS_FRAME, SS_DATA, SS_DONE} mics_ss_state_type;
   typedef struct packed {
      mics_ss_state_type st;
      logic [3:0]  div;
      logic [5:0]  cnt;
      logic [31:0] sh;
      logic [31:0] rx;
      logic        clk;
      logic [1:0]  chan;
      logic        rd;
      logic        sync1;
      logic        sync2;
   } mics_ss_type;
   mics_ss_type q, d;
   logic tick;

   assign tick     = (q.div == 4'(mics_pkg::SER_DIV - 1));
   assign done     = (q.st == SS_DONE);
   assign rdata    = q.rx;
   assign ser_clk  = q.clk;
   assign ser_cmd  = q.sh[31];
   assign ser_chan = q.chan;

   always_comb begin
      d = q;
      d.sync1 = ser_din;
      d.sync2 = q.sync1;
      d.div = (q.st == SS_IDLE || tick) ? 4'h0 : q.div + 4'h1;
      unique case (q.st)
         SS_IDLE: begin
            if (start) begin
               // Frame: bcast, dev id (zero on broadcast), opcode, reg addr
               d.sh = {op.bcast, (op.bcast ? 5'h00 : op.dev_id), op.opcode, op.reg_addr, 12'h000};
               d.chan = op.channel;
               d.rd = is_read;
               d.cnt = 6'(mics_pkg::FRAME_BITS);
               d.st = SS_FRAME;
            end
         end
         SS_FRAME, SS_DATA: begin
            if (tick) begin
               d.clk = ~q.clk;
               if (q.clk) begin
                  d.sh = {q.sh[30:0], 1'b0};
                  d.rx = {q.rx[30:0], q.sync2};
                  d.cnt = q.cnt - 6'h1;
                  if (q.cnt == 6'h1) begin
                     if (q.st == SS_FRAME) begin
                        d.st = SS_DATA;
                        d.cnt = 6'(mics_pkg::SER_BITS);
                        d.sh = q.rd ? 32'h0000_0000 : wdata;
                     end else begin
                        d.st = SS_DONE;
                     end
                  end
               end
            end
         end
         SS_DONE: d.st = SS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule // mics_serial_shift
`default_nettype wire

// ---- test/mics_seq_properties.sv ----
// Port checker for the init command sequencer
`timescale 1ns/100ps
`default_nettype none
module mics_seq_properties (
   // Clock and reset
   input wire logic                       ref_clk,
   input wire logic                       rst,
   // Register port
   input wire mics_pkg::mics_cfg_req_type cfg_req,
   input wire logic [31:0]                cfg_rdata,
   // Chain and expansion outputs
   input wire logic                       ser_clk,
   input wire logic [1:0]                 ser_chan,
   input wire logic [31:0]                exp_cfg_a,
   input wire logic [31:0]                exp_cfg_b,
   input wire logic                       clamp_en_a,
   input wire logic                       clamp_en_b
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [31:0] dat_q;
   // Bench writes the data word only while idle, so no busy tracking here
   always_ff @(posedge ref_clk or posedge rst)
      if (rst) dat_q <= 32'h0;
      else if (cfg_req.wr && cfg_req.addr == 8'h90) dat_q <= cfg_req.wdata;
   sequence s_cmd;
      cfg_req.wr && cfg_req.addr == 8'h94 && cfg_req.wdata[23];
   endsequence
   sequence s_ld(logic [4:0] op);
      s_cmd ##0 cfg_req.wdata[4:0] == op;
   endsequence
   property p_clamp_a; clamp_en_a == (exp_cfg_a[25:24] == 2'h3); endproperty
   property p_clamp_b; clamp_en_b == (exp_cfg_b[25:24] == 2'h3); endproperty
   property p_resv; ((exp_cfg_a | exp_cfg_b) & 32'hfcff_ffff) == 32'h0; endproperty
   property p_load_a; s_ld(5'h19) |-> ##2 exp_cfg_a == (dat_q & 32'h0300_0000); endproperty
   property p_load_b; s_ld(5'h1a) |-> ##2 exp_cfg_b == (dat_q & 32'h0300_0000); endproperty
   property p_unmap; !(cfg_req.addr inside {8'h90, 8'h94}) |-> cfg_rdata == 32'h0; endproperty
   property p_quiet;
      // A wrongly started frame first raises the serial clock about 12 cycles in
      s_cmd ##0 cfg_req.wdata[4:0] inside {5'h03, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0c, 5'h0e,
         5'h0f, 5'h1e, 5'h1f} |-> ##1 !ser_clk [*8] ##4 !ser_clk [*8];
   endproperty
   property p_chan;
      logic [1:0] ch;
      (s_cmd, ch = cfg_req.wdata[21:20]) ##0 !cfg_req.wdata[4:0] |-> ##[1:4] ser_chan == ch;
   endproperty
   a_clamp_a: assert property (p_clamp_a) else $error("clamp A");
   a_clamp_b: assert property (p_clamp_b) else $error("clamp B");
   a_resv: assert property (p_resv) else $error("reserved bits");
   a_load_a: assert property (p_load_a) else $error("load A");
   a_load_b: assert property (p_load_b) else $error("load B");
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   a_quiet: assert property (p_quiet) else $error("reserved op traffic");
   a_chan: assert property (p_chan) else $error("channel");
endmodule // mics_seq_properties
bind mics_sequencer mics_seq_properties u_props (.ref_clk, .rst, .cfg_req, .cfg_rdata,
   .ser_clk, .ser_chan, .exp_cfg_a, .exp_cfg_b, .clamp_en_a, .clamp_en_b);
`default_nettype wire

// ---- test/mics_chain_dev.sv ----
// Behavioural memory device on the serial control chain
`timescale 1ns/100ps
`default_nettype none
module mics_chain_dev #(
   parameter logic [4:0] DEV_ID = 5'h03
) (
   // Clock and reset
   input wire logic     ref_clk,
   input wire logic     rst,
   // Serial chain
   input wire logic     ser_clk,
   input wire logic     ser_cmd,
   output logic         ser_din,
   // Observation
   output logic [19:0]  frame,
   output logic [31:0]  wseen,
   output int           nframes
);
   logic [23:0] sh;
   logic [31:0] val;
   logic        drv  = 1'b0;
   logic        dbit = 1'b0;
   int          n;
   // Bits are taken on the rising serial edge; a read bit is set up there and
   // held through the falling edge at which the sequencer samples it
   always @(posedge ser_clk or negedge ser_clk or posedge rst) begin
      if (rst) begin
         n = 0;
         nframes = 0;
         drv = 1'b0;
      end else if (ser_clk) begin
         sh = {sh[22:0], ser_cmd};
         n = n + 1;
         if (n == 24) begin
            // Frame is bcast, id, opcode, address, then four pad bits
            frame = sh[23:4];
            nframes = nframes + 1;
            val = 32'hc3a5_0000 | 32'(sh[12:4]);
            drv = sh[17:13] == 5'h00 && (sh[23] || sh[22:18] == DEV_ID);
         end
         if (n >= 25) begin
            dbit = val[56 - n];
            wseen = {wseen[30:0], ser_cmd};
         end
         if (n == 56) n = 0;
      end else if (n == 0) begin
         // Last data bit has been sampled, so the line is released
         drv = 1'b0;
      end
   end
   // Released line toggles so a stale bit is never mistaken for data
   always @(posedge ref_clk or posedge rst)
      if (rst) ser_din <= 1'b0;
      else ser_din <= drv ? dbit : ~ser_din;
endmodule // mics_chain_dev
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the init command sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic                       ref_clk, rst, ser_clk, ser_cmd, ser_din, clamp_en_a, clamp_en_b;
   mics_pkg::mics_cfg_req_type cfg_req;
   logic [31:0]                cfg_rdata, exp_cfg_a, exp_cfg_b, d, c, r, wseen;
   logic [31:0]                exp_model [2] = '{32'h0000_0000, 32'h0000_0000};
   logic [1:0]                 ser_chan;
   logic [19:0]                frame;
   logic [4:0]                 rsv [10] = '{5'h03, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0c, 5'h0e,
                                            5'h0f, 5'h1e, 5'h1f};
   int                         nframes, nf, miscompares, checked;
   mics_sequencer DUT (.ref_clk, .rst, .cfg_req, .cfg_rdata, .ser_clk, .ser_cmd, .ser_chan,
      .ser_din, .exp_cfg_a, .exp_cfg_b, .clamp_en_a, .clamp_en_b);
   mics_chain_dev u_dev (.ref_clk, .rst, .ser_clk, .ser_cmd, .ser_din, .frame, .wseen,
      .nframes);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk) #1;
      cfg_req.addr = a;
      cfg_req.wdata = v;
      cfg_req.wr = 1'b1;
      @(posedge ref_clk) #1;
      cfg_req.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk) #1;
      cfg_req.addr = a;
      #2 v = cfg_rdata;
   endtask
   // Issue a command, poll until the initiate bit drops, check readback
   task automatic run(input logic [31:0] cmd);
      wr(8'h94, cmd);
      for (int i = 0; i < 3000; i++) begin
         rd(8'h94, r);
         if (r[23] === 1'b0) break;
      end
      chk(r, cmd & 32'h003f_ffff);
   endtask
   task automatic tally_and_finish;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #300000;
      miscompares++;
      tally_and_finish;
   end
   initial begin
      cfg_req = 42'h0;
      miscompares = 0;
      checked = 0;
      rst = 1'b1;
      void'($urandom(43));
      repeat (12) @(posedge ref_clk);
      #1 rst = 1'b0;
      chk(exp_cfg_a | exp_cfg_b | {clamp_en_a, clamp_en_b}, 32'h0);
      rd(8'h98, r);
      chk(r, 32'h0);
      for (int i = 0; i < 6; i++) begin
         d = $urandom;
         if (i < 2) d[25:24] = 2'h3;
         wr(8'h90, d);
         run(i[0] ? 32'h0080_001a : 32'h0080_0019);
         exp_model[i % 2] = d & 32'h0300_0000;
         chk(exp_cfg_a, exp_model[0]);
         chk(exp_cfg_b, exp_model[1]);
         chk(i[0] ? clamp_en_b : clamp_en_a, 32'(d[25:24] == 2'h3));
      end
      nf = nframes;
      foreach (rsv[k]) run(32'h0080_0000 | ($urandom & 32'h003f_ffe0) | rsv[k]);
      // Keeps the next frame out of the quiet window after a reserved opcode
      repeat (20) @(posedge ref_clk);
      chk(nframes, nf);
      for (int k = 0; k < 4; k++) begin
         d = $urandom;
         wr(8'h90, d);
         c = ($urandom & 32'h0037_fc00) | 32'h0080_0000;
         c[19] = k[0];
         c[9:5] = k[0] ? 5'($urandom) : 5'h03;
         c[4:0] = k[1] ? 5'h01 : 5'h00;
         run(c);
         chk(frame, {c[19], c[19] ? 5'h00 : c[9:5], c[4:0], c[18:10]});
         chk(wseen, k[1] ? d : 32'h0000_0000);
         rd(8'h90, r);
         chk(r, k[1] ? d : (32'hc3a5_0000 | 32'(c[18:10])));
      end
      tally_and_finish;
   end
endmodule // tb
`default_nettype wire
